//--- rtc_bus_pkg.sv
// shared constants and types for the clock/calendar RAM bus model
//
// Notes on behaviour
// - bus-type select high picks strobe-plus-level mode
// - rate code sets periodic interrupt period
// - square wave taps divider, 8192 Hz to 2 Hz
// - square wave only when enabled and power good
// - address strobe fall latches six address bits
// - read ends, bus released to high impedance
// - level mode: drive while strobe high, write trailing
// - direction level high reads, low writes
// - separate mode: read is output enable, write-enable low
// - address latched even when chip unselected
// - master holds chip select through strobes
// - master holds write data stable late strobe
// - no access while supply below power-fail threshold
// - stay deselected 100 ms after power up
// - interrupt open-drain low while enabled flag set
// - master clears interrupt by reading flag register
// - reset input clears enables, flags, interrupt
// - no access while reset input low
// - reset input leaves time and RAM alone
// - system holds reset over 200 ms at power-up
// - flag read clears flags, holds new events
package rtc_bus_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  // byte locations of control bytes
  localparam logic [5:0] ADDR_RATE  = 6'h0a;
  localparam logic [5:0] ADDR_CTRL  = 6'h0b;
  localparam logic [5:0] ADDR_FLAGS = 6'h0c;
  localparam logic [5:0] ADDR_STAT  = 6'h0d;
  // control byte field positions
  localparam int BIT_SQUARE_WAVE_ENABLE = 3;
  localparam int BIT_UIE  = 4;
  localparam int BIT_AIE  = 5;
  localparam int BIT_PIE  = 6;
  localparam int BIT_UF   = 4;
  localparam int BIT_AF   = 5;
  localparam int BIT_PF   = 6;
  localparam int BIT_INTERRUPT_SUMMARY_FLAG = 7;
  // divider input: 32768 Hz reference, 15 stages
  localparam int REF_HZ = 32768;
  localparam int DIV_STAGES = 15;
  localparam int REF_DIV = CLK_HZ / REF_HZ;
  localparam int POWERUP_MS = 100;
  localparam int POWERUP_CYC = CLK_HZ / 1000 * POWERUP_MS;
  localparam int RESET_HOLD_MS = 200;
  // APB register word offsets of the host controller
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_WDATA  = 8'h04;
  localparam logic [7:0] REG_RDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_PINS   = 8'h10;
  // bus phase of the host lasts this many clocks plus one
  localparam int PHASE_CYC = 2;

  typedef enum logic [2:0] {
    H_IDLE, H_ADDR, H_GAP, H_DATA, H_END
  } host_state_t;

  // rate code to divider tap bit (bit k toggles at REF/2^(k+1))
  function automatic logic [3:0] tapOf(input logic [3:0] rate);
    unique case (rate)
      4'h1: tapOf = 4'h6;
      4'h2: tapOf = 4'h7;
      default: tapOf = rate - 4'h2;
    endcase
  endfunction
endpackage

//--- rtc_bus_if.sv
// multiplexed bus between the clock/calendar RAM and its host
`timescale 1ns/1ps
interface rtc_bus_if;
  logic [7:0] busHost;
  logic       busHostOe;
  logic [7:0] busDev;
  logic       busDevOe;
  logic [7:0] busLevel;
  logic       addressStrobe;
  logic       dataStrobe;
  logic       writeLevel;
  logic       chipSelect_n;
  logic       busTypeSelect;
  logic       resetIn_n;
  logic       irqOe;
  logic       irq_n;
  logic       squareWave;
  // wired resolution, pull-up on the interrupt line
  assign busLevel = busDevOe ? busDev : (busHostOe ? busHost : 8'hff);
  assign irq_n    = ~irqOe;
  modport device (input busLevel, addressStrobe, dataStrobe, writeLevel, chipSelect_n,
                  busTypeSelect, resetIn_n, output busDev, busDevOe, irqOe, squareWave);
  modport host (input busLevel, irq_n, squareWave, output busHost, busHostOe, addressStrobe,
                dataStrobe, writeLevel, chipSelect_n, busTypeSelect, resetIn_n);
endinterface

//--- rtc_device.sv
// clock/calendar RAM device end: bus decode, rate divider, flags, interrupt
`timescale 1ns/1ps
module rtc_device #(
  parameter int POWERUP_CYCLES = rtc_bus_pkg::POWERUP_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  rtc_bus_if.device bus,
  input  wire logic powerGood,
  input  wire logic oscRunning,
  input  wire logic alarmEvent,
  input  wire logic updateEvent
);
  import rtc_bus_pkg::*;

  typedef struct packed {
    logic [63:0][7:0] mem;
    logic [5:0]       addr;
    logic             asPrev;
    logic             dsPrev;
    logic             wrPrev;
    logic [7:0]       wrData;
    logic             rdActive;
    logic             flagRead;
    logic [7:0]       flagSnap;
    logic [7:0]       busOut;
    logic             busOe;
    logic [14:0]      div;
    logic [15:0]      refCnt;
    logic             tapPrev;
    logic [31:0]      puCnt;
    logic             sqw;
  } dev_state_t;

  dev_state_t s, next_s;
  logic selected, levelMode, readNow, writeDone, tick, tapBit, irqActive, periodicEvt;

  always_comb begin
    next_s = s;
    levelMode = bus.busTypeSelect;
    tick = (s.refCnt == 16'(REF_DIV - 1));
    next_s.refCnt = tick ? 16'h0 : s.refCnt + 16'h1;
    if (tick) next_s.div = s.div + 15'h1; // timekeeping runs regardless
    tapBit = (s.mem[ADDR_RATE][3:0] == 4'h0) ? 1'b0 : s.div[tapOf(s.mem[ADDR_RATE][3:0])];
    next_s.tapPrev = tapBit;
    periodicEvt = tapBit & ~s.tapPrev;
    // power-up deselect timer, only counts with oscillator running
    if (!powerGood) next_s.puCnt = 32'h0;
    else if (oscRunning && s.puCnt < 32'(POWERUP_CYCLES)) next_s.puCnt = s.puCnt + 32'h1;
    selected = ~bus.chipSelect_n & powerGood & bus.resetIn_n
             & (s.puCnt >= 32'(POWERUP_CYCLES));
    readNow = levelMode ? (bus.dataStrobe & bus.writeLevel) : ~bus.dataStrobe;
    writeDone = levelMode ? (s.dsPrev & ~bus.dataStrobe & ~s.wrPrev)
                          : (~s.wrPrev & bus.writeLevel);
    next_s.asPrev = bus.addressStrobe;
    next_s.dsPrev = bus.dataStrobe;
    next_s.wrPrev = bus.writeLevel;
    if (levelMode) next_s.wrPrev = bus.writeLevel | ~bus.dataStrobe;
    next_s.wrData = bus.busLevel; // last value before trailing edge
    if (s.asPrev && !bus.addressStrobe) next_s.addr = bus.busLevel[5:0];
    // read: drive while strobe active, release when it ends
    next_s.busOe = selected & readNow;
    next_s.rdActive = selected & readNow;
    if (selected && readNow) begin
      if (!s.rdActive) begin
        next_s.flagSnap = s.mem[ADDR_FLAGS];
        next_s.busOut = s.mem[s.addr];
      end
      next_s.flagRead = (s.addr == ADDR_FLAGS);
    end
    // flag events set the sticky flags; a held read freezes the snapshot only
    next_s.mem[ADDR_FLAGS][BIT_PF] = s.mem[ADDR_FLAGS][BIT_PF] | periodicEvt;
    next_s.mem[ADDR_FLAGS][BIT_AF] = s.mem[ADDR_FLAGS][BIT_AF] | alarmEvent;
    next_s.mem[ADDR_FLAGS][BIT_UF] = s.mem[ADDR_FLAGS][BIT_UF] | updateEvent;
    if (s.rdActive && !(selected && readNow) && s.flagRead) begin
      // clear only what was read; newer events stay pending
      next_s.mem[ADDR_FLAGS][6:4] = (s.mem[ADDR_FLAGS][6:4] & ~s.flagSnap[6:4])
                                  | {periodicEvt, alarmEvent, updateEvent};
      next_s.flagRead = 1'b0;
    end
    if (selected && writeDone && s.addr != ADDR_FLAGS && s.addr != ADDR_STAT) begin
      next_s.mem[s.addr] = s.wrData;
    end
    irqActive = |(s.mem[ADDR_FLAGS][6:4] & s.mem[ADDR_CTRL][6:4]);
    next_s.mem[ADDR_FLAGS][BIT_INTERRUPT_SUMMARY_FLAG] = |(next_s.mem[ADDR_FLAGS][6:4] & next_s.mem[ADDR_CTRL][6:4]);
    if (!bus.resetIn_n && powerGood) begin
      // time and RAM bytes are untouched
      next_s.mem[ADDR_CTRL][6:3] = 4'h0;
      next_s.mem[ADDR_FLAGS][7:4] = 4'h0;
      next_s.busOe = 1'b0;
    end
    next_s.sqw = s.mem[ADDR_CTRL][BIT_SQUARE_WAVE_ENABLE] & powerGood & tapBit;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bus.busDev = s.busOut;
  assign bus.busDevOe = s.busOe;
  assign bus.irqOe = irqActive & s.mem[ADDR_FLAGS][BIT_INTERRUPT_SUMMARY_FLAG];
  assign bus.squareWave = s.sqw;
endmodule

//--- rtc_host.sv
// host end: APB slave registers driving the multiplexed bus cycles
`timescale 1ns/1ps
module rtc_host (
  input  wire logic        clk,
  input  wire logic        rst_n,
  rtc_bus_if.host          bus,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  import rtc_bus_pkg::*;

  typedef struct packed {
    host_state_t st;
    logic [7:0]  cnt;
    logic [5:0]  addr;
    logic        isWrite;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        busy;
    logic        done;
    logic        mode;
    logic        rstOut;
    logic        as;
    logic        ds;
    logic        wr;
    logic        cs;
    logic        oe;
    logic [7:0]  bout;
    logic [31:0] prd;
  } host_st_t;

  host_st_t h, next_h;
  logic access;

  always_comb begin
    next_h = h;
    access = psel & penable;
    next_h.prd = 32'h0;
    unique case (paddr)
      REG_WDATA:  next_h.prd = {24'h0, h.wdata};
      REG_RDATA:  next_h.prd = {24'h0, h.rdata};
      REG_STATUS: next_h.prd = {29'h0, ~bus.irq_n, h.done, h.busy};
      REG_PINS:   next_h.prd = {29'h0, bus.squareWave, h.rstOut, h.mode};
      default:    next_h.prd = 32'h0;
    endcase
    if (access && pwrite) begin
      unique case (paddr)
        REG_CMD: if (!h.busy) begin
          // bit 8 write, bits 5:0 byte address
          next_h.addr = pwdata[5:0];
          next_h.isWrite = pwdata[8];
          next_h.busy = 1'b1;
          next_h.done = 1'b0;
          next_h.st = H_ADDR;
          next_h.cnt = 8'h0;
        end
        REG_WDATA: next_h.wdata = pwdata[7:0];
        REG_PINS: begin
          next_h.mode = pwdata[0];
          next_h.rstOut = pwdata[1]; // software times the hold
        end
        default: ;
      endcase
    end
    unique case (h.st)
      H_IDLE: begin
        next_h.as = 1'b0;
        next_h.ds = ~h.mode;
        next_h.wr = 1'b1;
        next_h.cs = 1'b1;
        next_h.oe = 1'b0;
      end
      H_ADDR: begin
        next_h.cs = 1'b0;
        next_h.as = 1'b1;
        next_h.oe = 1'b1;
        next_h.bout = {2'b00, h.addr};
        if (h.cnt == 8'(PHASE_CYC)) next_h.st = H_GAP;
      end
      H_GAP: begin
        next_h.as = 1'b0;
        if (h.cnt == 8'(PHASE_CYC)) next_h.st = H_DATA;
      end
      H_DATA: begin
        next_h.oe = h.isWrite;
        next_h.bout = h.wdata;
        if (h.mode) begin
          next_h.wr = ~h.isWrite;
          next_h.ds = 1'b1;
        end else begin
          next_h.ds = h.isWrite;
          next_h.wr = ~h.isWrite;
        end
        if (h.cnt == 8'(PHASE_CYC)) begin
          next_h.rdata = bus.busLevel;
          next_h.st = H_END;
        end
      end
      H_END: begin
        // strobes end first, select held two more clocks and data three
        next_h.ds = ~h.mode;
        next_h.wr = h.mode ? h.wr : 1'b1;
        if (h.cnt == 8'(PHASE_CYC)) begin
          next_h.st = H_IDLE;
          next_h.busy = 1'b0;
          next_h.done = 1'b1;
          next_h.cs = 1'b1;
        end
      end
      default: next_h.st = H_IDLE;
    endcase
    // counted after the phase decision, so every new phase restarts from zero
    next_h.cnt = (h.st == H_IDLE || next_h.st != h.st) ? 8'h0 : h.cnt + 8'h1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      h <= '0;
      h.wr <= 1'b1;
      h.cs <= 1'b1;
      h.ds <= 1'b1;
    end else begin
      h <= next_h;
    end
  end

  assign prdata = h.prd;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign bus.busHost = h.bout;
  assign bus.busHostOe = h.oe;
  assign bus.addressStrobe = h.as;
  assign bus.dataStrobe = h.ds;
  assign bus.writeLevel = h.wr;
  assign bus.chipSelect_n = h.cs;
  assign bus.busTypeSelect = h.mode;
  assign bus.resetIn_n = h.rstOut;
endmodule

//--- rtc_bus_checker.sv
// bus rules between host and device ends
`timescale 1ns/1ps
module rtc_bus_checker (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] busHost,
  input wire logic       busHostOe,
  input wire logic       busDevOe,
  input wire logic       dataStrobe,
  input wire logic       writeLevel,
  input wire logic       chipSelect_n,
  input wire logic       busTypeSelect,
  input wire logic       resetIn_n,
  input wire logic       irqOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_no_contention: assert property (!(busDevOe && busHostOe))
    else $error("both ends drive the bus");
  a_drive_selected: assert property ($rose(busDevOe) |-> !chipSelect_n)
    else $error("device drives while unselected");
  a_level_read_drive: assert property (busTypeSelect && $rose(busDevOe) |-> dataStrobe && writeLevel)
    else $error("level mode drive outside read strobe");
  a_sep_read_drive: assert property (!busTypeSelect && $rose(busDevOe) |-> !dataStrobe)
    else $error("separate mode drive outside read strobe");
  a_level_release: assert property (busTypeSelect && busDevOe && $fell(dataStrobe) |-> ##[1:2] !busDevOe)
    else $error("bus not released after strobe fall");
  a_sep_release: assert property (!busTypeSelect && busDevOe && $rose(dataStrobe) |-> ##[1:2] !busDevOe)
    else $error("bus not released after read strobe rise");
  a_irq_reset: assert property ((!resetIn_n)[*3] |-> !irqOe)
    else $error("interrupt pulled during reset");
  a_access_reset: assert property ((!resetIn_n)[*2] |-> !$rose(busDevOe))
    else $error("access during reset");
  a_select_held: assert property (!busTypeSelect && (!dataStrobe || !writeLevel) |-> !chipSelect_n)
    else $error("strobe without chip select");
  a_wdata_stable: assert property ((!busTypeSelect && !writeLevel)[*2] |-> busHostOe && $stable(busHost))
    else $error("write data not held");
endmodule

//--- tb_top.sv
// self-checking bench: APB host end driving the device end
`timescale 1ns/1ps
module tb_top;
  import rtc_bus_pkg::*;
  typedef struct packed {
    logic [31:0] e;
    logic [31:0] m;
  } note_t;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        powerGood, oscRunning, alarmEvent, updateEvent;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rs, seed;
  note_t       notes[$];
  note_t       nt;
  int          failures, comparisons, cyc, edges;
  rtc_bus_if bus ();
  rtc_host i_rtc_host (.clk(clk), .rst_n(rst_n), .bus(bus.host), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // short power-up window keeps the run brief
  rtc_device #(.POWERUP_CYCLES(40)) i_rtc_device (.clk(clk), .rst_n(rst_n), .bus(bus.device),
    .powerGood(powerGood), .oscRunning(oscRunning), .alarmEvent(alarmEvent),
    .updateEvent(updateEvent));
  rtc_bus_checker i_rtc_bus_checker (.clk(clk), .rst_n(rst_n), .busHost(bus.busHost),
    .busHostOe(bus.busHostOe), .busDevOe(bus.busDevOe), .dataStrobe(bus.dataStrobe),
    .writeLevel(bus.writeLevel), .chipSelect_n(bus.chipSelect_n),
    .busTypeSelect(bus.busTypeSelect), .resetIn_n(bus.resetIn_n), .irqOe(bus.irqOe));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // idle cycle after each transfer so psel is never assigned twice at one edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m);
    if (!w) notes.push_back('{e, m});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rs = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic op(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [7:0] m);
    int k;
    apb(1'b1, REG_WDATA, {24'h0, d}, 32'h0, 32'h0);
    apb(1'b1, REG_CMD, {23'h0, w, 2'b00, a}, 32'h0, 32'h0);
    apb(1'b0, REG_STATUS, 32'h0, 32'h0, 32'h0);
    for (k = 0; k < 50 && rs[0] !== 1'b0; k++) apb(1'b0, REG_STATUS, 32'h0, 32'h0, 32'h0);
    if (!w) apb(1'b0, REG_RDATA, 32'h0, {24'h0, d}, {24'h0, m});
  endtask
  task automatic sqw(input int lo, input int hi);
    edges = 0;
    repeat (1300) @(posedge clk);
    comparisons++;
    if (edges < lo || edges > hi) begin
      failures++;
      $display("BAD %0t square wave edges %0d", $time, edges);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 40000) begin
      failures++;
      end_sim();
    end
  end
  always @(bus.squareWave) edges++;
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt.m != 0) begin
        comparisons++;
        if ((prdata & nt.m) !== nt.e) begin
          failures++;
          $display("BAD %0t read %h expected %h", $time, prdata & nt.m, nt.e);
        end
      end
    end
  end
  initial begin
    logic [5:0] a;
    logic [7:0] d;
    {psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
    {powerGood, oscRunning, alarmEvent, updateEvent} = 4'hc;
    {seed, failures, comparisons, cyc, edges} = {32'd49, 128'h0};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (50) @(posedge clk);
    op(1'b0, 6'h20, 8'hff, 8'hff);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, REG_PINS, {31'h1, m[0]}, 32'h0, 32'h0);
      for (int i = 0; i < 4; i++) begin
        seed = xs(seed);
        a = 6'h0e + 6'(seed[15:8] % 8'd50);
        d = seed[7:0];
        op(1'b1, a, d, 8'h0);
        op(1'b0, a, d, 8'hff);
      end
    end
    op(1'b1, ADDR_CTRL, 8'h20, 8'h0);
    alarmEvent <= 1'b1;
    updateEvent <= 1'b1;
    @(posedge clk);
    {alarmEvent, updateEvent} <= 2'b00;
    repeat (3) @(posedge clk);
    apb(1'b0, REG_STATUS, 32'h0, 32'h4, 32'h4);
    op(1'b0, ADDR_FLAGS, 8'hb0, 8'hf0);
    op(1'b0, ADDR_FLAGS, 8'h00, 8'hf0);
    apb(1'b0, REG_STATUS, 32'h0, 32'h0, 32'h4);
    op(1'b1, ADDR_RATE, 8'h03, 8'h0);
    op(1'b1, ADDR_CTRL, 8'h48, 8'h0);
    sqw(1, 3);
    apb(1'b0, REG_STATUS, 32'h0, 32'h4, 32'h4);
    op(1'b0, ADDR_FLAGS, 8'hc0, 8'hf0);
    powerGood <= 1'b0;
    // a high output may still fall once as power drops; not a toggle
    repeat (2) @(posedge clk);
    sqw(0, 0);
    op(1'b1, a, ~d, 8'h0);
    op(1'b0, a, 8'hff, 8'hff);
    powerGood <= 1'b1;
    op(1'b0, a, 8'hff, 8'hff);
    repeat (50) @(posedge clk);
    op(1'b0, a, d, 8'hff);
    apb(1'b1, REG_PINS, 32'h1, 32'h0, 32'h0);
    repeat (5) @(posedge clk);
    apb(1'b1, REG_PINS, 32'h3, 32'h0, 32'h0);
    op(1'b0, ADDR_CTRL, 8'h00, 8'h78);
    op(1'b0, ADDR_RATE, 8'h03, 8'h0f);
    op(1'b0, a, d, 8'hff);
    sqw(0, 0);
    end_sim();
  end
endmodule
